//--- rtl/vtr_map.svh
// Address map, field positions and reset values of the VLAN table slice.
// Assumes byte addresses on an 18-bit AXI4-Lite bus with 32-bit data.
`ifndef VTR_MAP_SVH
`define VTR_MAP_SVH

// ----------------------------------------
// Timestamp latency-adjust register
// ----------------------------------------
`define VTR_TS_ADJ_OFS 18'h0041c
`define VTR_TS_CORR_EN_BIT 16
`define VTR_TS_LAT_MSB 15
`define VTR_TS_LAT_RST_TOD 16'h00d3
`define VTR_TS_LAT_RST_CF 16'h0183
`define VTR_TS_CORR_EN_RST 1'b0

// ----------------------------------------
// VLAN tables
// ----------------------------------------
`define VTR_TBL_DEPTH 4096
`define VTR_TBL_IDX_W 12
`define VTR_XLATE_MSB 11
`define VTR_STRIP_BIT 12
`define VTR_TAG_BIT 13
`define VTR_TX_TBL_BASE 18'h04000
`define VTR_TX_TBL_END 18'h07fff
`define VTR_RX_TBL_BASE 18'h08000
`define VTR_RX_TBL_END 18'h0bfff

// ----------------------------------------
// Forwarded windows
// ----------------------------------------
`define VTR_PTP_RX_BASE 18'h10000
`define VTR_PTP_RX_END 18'h10fff
`define VTR_PTP_TX_BASE 18'h11000
`define VTR_PTP_TX_END 18'h117ff
`define VTR_PTP_TX_SECT_BYTES 256
`define VTR_AVB_CFG_BASE 18'h12000
`define VTR_AVB_CFG_END 18'h1201b
`define VTR_AVB_RTC_BASE 18'h12800
`define VTR_AVB_RTC_END 18'h128ff

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define VTR_RESP_OKAY 2'b00
`define VTR_RESP_DECERR 2'b11

`endif

//--- rtl/vtr_pkg.sv
// Types shared by the VLAN table slice and its surroundings.
// Assumes nothing beyond a SystemVerilog tool.
package vtr_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // One table entry, fields at fixed positions in every build
  typedef struct packed {
    logic tag;
    logic strip;
    logic [11:0] xlate;
  } vtr_entry_t;

  // Which window an address falls in
  typedef enum logic [2:0] {
    VTR_RG_NONE = 3'b000,
    VTR_RG_TS_ADJ = 3'b001,
    VTR_RG_TX_TBL = 3'b010,
    VTR_RG_RX_TBL = 3'b011,
    VTR_RG_PTP_RX = 3'b100,
    VTR_RG_PTP_TX = 3'b101,
    VTR_RG_AVB_CFG = 3'b110,
    VTR_RG_AVB_RTC = 3'b111
  } vtr_region_t;

  // Access passed on to the PTP and AVB blocks
  typedef struct packed {
    vtr_region_t region;
    logic [17:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr;
    logic rd;
  } vtr_ext_req_t;

  // Transmit timestamp correction settings
  typedef struct packed {
    logic corr_en;
    logic [15:0] latency;
  } vtr_ts_adj_t;

endpackage

//--- rtl/vtr_regs.sv
// Register slice: timestamp latency adjust, TX/RX VLAN tables, window decode.
// Assumes an AXI4-Lite master on ref_clk_i and PTP/AVB blocks that answer
// forwarded reads combinationally in the cycle of the read strobe.
`include "vtr_map.svh"

// Notes on behaviour
// [R1] Latency register exists only with timestamping
// [R2] Correction enable bit gates timestamp adjustment
// [R3] Sixteen-bit latency field, nanoseconds, resets 0xd3
// [R4] Correction-field format uses 387 ns default
// [R5] Two tables, always 4096 entries each
// [R6] Entry: 12-bit translation, strip, tag bits
// [R7] Absent function bits ignore writes, read zero
// [R8] Width set by which functions are built
// [R9] One entry per 32-bit bus word
// [R10] Field positions fixed in every build
// [R11] Transmit table window 0x4000 to 0x7fff
// [R12] Receive table window 0x8000 to 0xbfff
// [R13] Software loads both tables before use
// [R14] Receive PTP buffer window at 0x10000
// [R15] Transmit PTP buffer, eight 256-byte sections
// [R16] AVB config and clock windows decoded
// [R17] Upper table word bits read zero
module vtr_regs #(
  parameter bit HAS_PTP = 1'b1,
  parameter bit CF_FORMAT = 1'b0,
  parameter bit TX_XLATE = 1'b1,
  parameter bit TX_STRIP = 1'b1,
  parameter bit TX_TAG = 1'b1,
  parameter bit RX_XLATE = 1'b1,
  parameter bit RX_STRIP = 1'b1,
  parameter bit RX_TAG = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // AXI4-Lite write address and data
  input wire logic [17:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [17:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Timestamp correction settings to the transmit path
  output vtr_pkg::vtr_ts_adj_t ts_adj_o,
  // Table lookups from the VLAN datapath
  input wire logic [11:0] tx_vid_i,
  output vtr_pkg::vtr_entry_t tx_entry_o,
  input wire logic [11:0] rx_vid_i,
  output vtr_pkg::vtr_entry_t rx_entry_o,
  // Forwarded PTP buffer and AVB accesses
  output vtr_pkg::vtr_ext_req_t ext_req_o,
  input wire logic [31:0] ext_rdata_i
);
  import vtr_pkg::*;

  // ----------------------------------------
  // Build-time shape
  // ----------------------------------------
  // Implemented bits per table; nothing above bit 13 ever exists
  localparam logic [31:0] TX_MASK = {18'h00000, TX_TAG, TX_STRIP, {12{TX_XLATE}}}; // see [R8]
  localparam logic [31:0] RX_MASK = {18'h00000, RX_TAG, RX_STRIP, {12{RX_XLATE}}}; // see [R8]
  // Latency default depends on timestamp format
  localparam logic [15:0] LAT_RST = CF_FORMAT ? `VTR_TS_LAT_RST_CF : `VTR_TS_LAT_RST_TOD; // see [R4]

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Window decode, used for both read and write addresses
  function automatic vtr_region_t region_of(input logic [17:0] a);
    if (a[17:2] == 16'(`VTR_TS_ADJ_OFS >> 2)) begin
      region_of = HAS_PTP ? VTR_RG_TS_ADJ : VTR_RG_NONE; // see [R1]
    end else if (a >= `VTR_TX_TBL_BASE && a <= `VTR_TX_TBL_END) begin
      region_of = VTR_RG_TX_TBL; // see [R11]
    end else if (a >= `VTR_RX_TBL_BASE && a <= `VTR_RX_TBL_END) begin
      region_of = VTR_RG_RX_TBL; // see [R12]
    end else if (a >= `VTR_PTP_RX_BASE && a <= `VTR_PTP_RX_END) begin
      region_of = VTR_RG_PTP_RX; // see [R14]
    end else if (a >= `VTR_PTP_TX_BASE && a <= `VTR_PTP_TX_END) begin
      region_of = VTR_RG_PTP_TX; // see [R15]
    end else if (a >= `VTR_AVB_CFG_BASE && a <= `VTR_AVB_CFG_END) begin
      region_of = VTR_RG_AVB_CFG; // see [R16]
    end else if (a >= `VTR_AVB_RTC_BASE && a <= `VTR_AVB_RTC_END) begin
      region_of = VTR_RG_AVB_RTC; // see [R16]
    end else begin
      region_of = VTR_RG_NONE;
    end
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync; // Release stages
  logic rst_n; // Synchronised reset, low active

  // Assert at once, release two edges later
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic wr_take; // Address and data accepted together
  vtr_region_t wr_rg; // Window of the write
  logic [31:0] wr_bits; // Bits the strobes allow

  // Both channels wait for each other; keeps one write in flight
  assign wr_take = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign s_axi_awready_o = wr_take;
  assign s_axi_wready_o = wr_take;
  assign wr_rg = region_of(s_axi_awaddr_i);
  assign wr_bits = lane_mask(s_axi_wstrb_i);

  // Write response, held until the master takes it
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `VTR_RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (wr_rg == VTR_RG_NONE) ? `VTR_RESP_DECERR : `VTR_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Timestamp latency-adjust register
  // ----------------------------------------
  // Byte-wise update; absent builds never decode it
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ts_adj_o.corr_en <= `VTR_TS_CORR_EN_RST; // see [R2]
      ts_adj_o.latency <= LAT_RST; // see [R3]
    end else if (wr_take && wr_rg == VTR_RG_TS_ADJ) begin
      if (s_axi_wstrb_i[2]) begin
        ts_adj_o.corr_en <= s_axi_wdata_i[`VTR_TS_CORR_EN_BIT]; // see [R2]
      end
      if (s_axi_wstrb_i[1]) begin
        ts_adj_o.latency[15:8] <= s_axi_wdata_i[`VTR_TS_LAT_MSB:8]; // see [R3]
      end
      if (s_axi_wstrb_i[0]) begin
        ts_adj_o.latency[7:0] <= s_axi_wdata_i[7:0]; // see [R3]
      end
    end
  end

  // ----------------------------------------
  // VLAN tables
  // ----------------------------------------
  logic [13:0] tbl_rd [2]; // Bus-side read of each table
  logic [13:0] tbl_lk [2]; // Registered datapath lookups

  // Table 0 transmits, table 1 receives; same shape, own mask
  for (genvar t = 0; t < 2; t++) begin : g_tbl
    localparam logic [31:0] MASK = (t == 0) ? TX_MASK : RX_MASK;
    localparam vtr_region_t RG = (t == 0) ? VTR_RG_TX_TBL : VTR_RG_RX_TBL;
    // No reset: contents are undefined until software loads them
    logic [13:0] mem [`VTR_TBL_DEPTH]; // see [R5] [R13]
    logic [31:0] keep; // Bits this write may change
    logic [11:0] lk_idx; // Datapath index
    logic [11:0] wr_idx; // Entry under write

    assign keep = MASK & wr_bits; // see [R7] [R17]
    assign lk_idx = (t == 0) ? tx_vid_i : rx_vid_i;
    assign wr_idx = s_axi_awaddr_i[13:2]; // see [R9]

    // Merge only implemented, strobed bits; others stay as they are
    always_ff @(posedge ref_clk_i) begin
      if (wr_take && wr_rg == RG) begin
        mem[wr_idx] <= (mem[wr_idx] & ~keep[13:0]) | (s_axi_wdata_i[13:0] & keep[13:0]); // see [R6] [R10]
      end
    end

    // Absent bits read as zero on both sides
    assign tbl_rd[t] = mem[s_axi_araddr_i[13:2]] & MASK[13:0]; // see [R7] [R9]

    // Lookup for the datapath, one cycle after the index
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        tbl_lk[t] <= 14'h0000;
      end else begin
        tbl_lk[t] <= mem[lk_idx] & MASK[13:0]; // see [R7]
      end
    end
  end

  assign tx_entry_o = vtr_entry_t'(tbl_lk[0]); // see [R10]
  assign rx_entry_o = vtr_entry_t'(tbl_lk[1]); // see [R10]

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic rd_take; // Read address accepted
  vtr_region_t rd_rg; // Window of the read
  logic [31:0] rd_word; // Word to return

  // A forwarded read waits while a forwarded write holds the strobe port
  assign rd_take = s_axi_arvalid_i && !s_axi_rvalid_o && !(wr_take && wr_rg[2] && rd_rg[2]);
  assign s_axi_arready_o = rd_take;
  assign rd_rg = region_of(s_axi_araddr_i);

  // Pick the answer; upper bits of table words are always zero
  always_comb begin
    rd_word = 32'h00000000;
    unique case (rd_rg)
      VTR_RG_TS_ADJ: rd_word = {15'h0000, ts_adj_o.corr_en, ts_adj_o.latency};
      VTR_RG_TX_TBL: rd_word = {18'h00000, tbl_rd[0]}; // see [R17]
      VTR_RG_RX_TBL: rd_word = {18'h00000, tbl_rd[1]}; // see [R17]
      VTR_RG_NONE: rd_word = 32'h00000000;
      default: rd_word = ext_rdata_i;
    endcase
  end

  // Read data held until the master takes it
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `VTR_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= (rd_rg == VTR_RG_NONE) ? `VTR_RESP_DECERR : `VTR_RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Forwarding to PTP buffers and AVB blocks
  // ----------------------------------------
  logic wr_ext; // Write lands in a forwarded window
  logic rd_ext; // Read lands in a forwarded window

  assign wr_ext = wr_take && wr_rg[2]; // see [R14] [R15] [R16]
  assign rd_ext = rd_take && rd_rg[2]; // see [R14] [R15] [R16]

  // A write wins the shared strobe port; a read then waits a cycle
  always_comb begin
    ext_req_o.wr = wr_ext;
    ext_req_o.rd = rd_ext && !wr_ext;
    ext_req_o.region = wr_ext ? wr_rg : rd_rg;
    ext_req_o.addr = wr_ext ? s_axi_awaddr_i : s_axi_araddr_i;
    ext_req_o.wdata = s_axi_wdata_i;
    ext_req_o.wstrb = s_axi_wstrb_i;
    if (!ext_req_o.wr && !ext_req_o.rd) begin
      ext_req_o.region = VTR_RG_NONE;
    end
  end

endmodule

//--- tb/vtr_regs_asserts.sv
// Checker for the bus handshakes and window decode of the table slice.
// Assumes it is bound into vtr_regs and sees only that module's ports.
`include "vtr_map.svh"
module vtr_regs_asserts (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Write channels
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bready_i,
  // Read channels
  input wire logic [17:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  // Forwarded access
  input wire vtr_pkg::vtr_ext_req_t ext_req_o
);
  import vtr_pkg::*;
  logic tbl_a; // Read aims at either table
  logic fwd_a; // Read aims at a forwarded window
  assign tbl_a = s_axi_araddr_i >= `VTR_TX_TBL_BASE && s_axi_araddr_i <= `VTR_RX_TBL_END;
  assign fwd_a = (s_axi_araddr_i >= `VTR_PTP_RX_BASE && s_axi_araddr_i <= `VTR_PTP_TX_END)
    || (s_axi_araddr_i >= `VTR_AVB_CFG_BASE && s_axi_araddr_i <= `VTR_AVB_CFG_END)
    || (s_axi_araddr_i >= `VTR_AVB_RTC_BASE && s_axi_araddr_i <= `VTR_AVB_RTC_END);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Accepted read and write
  sequence s_rd;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence s_wr;
    s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  endsequence
  AST_WR_ACK: assert property (s_wr |=> s_axi_bvalid_o)
    else $error("write not answered next cycle");
  AST_WR_REFUSE: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  AST_B_HOLD: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_RD_ACK: assert property (s_rd |=> s_axi_rvalid_o)
    else $error("read not answered next cycle");
  AST_RD_REFUSE: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
  AST_R_HOLD: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  AST_TBL_RD: assert property (
    s_rd ##0 tbl_a |=> s_axi_rresp_o == `VTR_RESP_OKAY && s_axi_rdata_o[31:14] == 18'h0)
    else $error("table read refused or upper bits set");
  AST_TS_RD: assert property (
    s_rd ##0 s_axi_araddr_i == `VTR_TS_ADJ_OFS |=>
    s_axi_rresp_o == `VTR_RESP_OKAY && s_axi_rdata_o[31:17] == 15'h0)
    else $error("latency register read wrong");
  AST_FWD_RD: assert property (
    s_rd ##0 fwd_a |-> ext_req_o.rd ##1 s_axi_rvalid_o)
    else $error("forwarded read not strobed");
  AST_FWD_IDLE: assert property (
    !s_axi_arvalid_i && !s_axi_awvalid_i |-> ext_req_o.region == VTR_RG_NONE && !ext_req_o.rd)
    else $error("forwarded port busy while idle");
endmodule
bind vtr_regs vtr_regs_asserts u_vtr_regs_asserts (
  .ref_clk_i, .nrst_i, .s_axi_awvalid_i, .s_axi_wvalid_i, .s_axi_awready_o,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bresp_o, .s_axi_bready_i, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
  .s_axi_rresp_o,
  .ext_req_o
);

//--- tb/vtr_fwd_model.sv
// Far-side model of the PTP buffers and AVB register blocks.
// Assumes reads are answered combinationally while the read strobe is up.
module vtr_fwd_model (
  // Forwarded request in, read data out
  input wire vtr_pkg::vtr_ext_req_t ext_req_i,
  output logic [31:0] ext_rdata_o
);
  import vtr_pkg::*;
  // Answer tells which window and word were hit; outside a strobe the
  // inverse is shown so stale data never passes for a real answer
  always_comb begin
    if (ext_req_i.rd) begin
      ext_rdata_o = {11'h0, ext_req_i.region, ext_req_i.addr};
    end else begin
      ext_rdata_o = ~{11'h0, ext_req_i.region, ext_req_i.addr};
    end
  end
endmodule

//--- tb/vlan_tables_ts_adjust_regs_tb_top.sv
// Self-checking bench for the VLAN table and latency register slice.
// Main instance is a full build: timestamping and every VLAN function present; a reduced build runs beside it.
`include "vtr_map.svh"
module vlan_tables_ts_adjust_regs_tb_top import vtr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, awr, wrr, bv, arr, rv;
  logic [17:0] awa = 18'h0, ara = 18'h0;
  logic [31:0] wd = 32'h0, rdat, erd;
  logic [3:0] ws = 4'h0;
  logic [1:0] bresp, rresp;
  logic [11:0] tvid = 12'h0, rvid = 12'h0;
  vtr_ts_adj_t ts;
  vtr_entry_t te, re;
  vtr_ext_req_t ext;
  // Outputs of the reduced build that shares the bus
  logic [31:0] rdat2;
  logic [1:0] rresp2;
  vtr_ts_adj_t ts2;
  vtr_entry_t te2, re2;
  vtr_ext_req_t fwd_last; // Last forwarded write seen on the strobe port
  int error_cnt = 0, n_checks = 0;
  logic [17:0] fa[4] = '{18'h10000, 18'h117fc, 18'h12018, 18'h12800};
  logic [31:0] fe[4] = '{32'h110000, 32'h1517fc, 32'h192018, 32'h1d2800};
  always #20 clk = ~clk;
  vtr_regs u_vtr_regs (.ref_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .ts_adj_o(ts), .tx_vid_i(tvid),
    .tx_entry_o(te), .rx_vid_i(rvid), .rx_entry_o(re), .ext_req_o(ext), .ext_rdata_i(erd));
  vtr_fwd_model u_vtr_fwd_model (.ext_req_i(ext), .ext_rdata_o(erd));
  // Reduced build on the same bus: correction-field default, some functions left out
  vtr_regs #(.CF_FORMAT(1'b1), .TX_XLATE(1'b0), .RX_STRIP(1'b0), .RX_TAG(1'b0))
    u_vtr_regs_part (.ref_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(), .s_axi_rdata_o(rdat2), .s_axi_rresp_o(rresp2),
    .s_axi_rvalid_o(), .s_axi_rready_i(rry), .ts_adj_o(ts2), .tx_vid_i(tvid),
    .tx_entry_o(te2), .rx_vid_i(rvid), .rx_entry_o(re2), .ext_req_o(), .ext_rdata_i(erd));
  // Keep the last forwarded write for the map test
  always @(posedge clk) begin
    if (ext.wr) begin
      fwd_last <= ext;
    end
  end
  // ----------------------------------------
  // Shared checks and bus cycles
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Host holds the response ready back one cycle, like a slow master
  task wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int i;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    for (i = 0; i < 20 && !awr; i++) @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    for (; i < 20 && !bv; i++) @(posedge clk);
    bry <= 1'b1;
    @(posedge clk);
    bry <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    if (i >= 20) results_late();
  endtask
  task rd(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    ara <= a;
    arv <= 1'b1;
    for (i = 0; i < 20 && !arr; i++) @(posedge clk);
    arv <= 1'b0;
    for (; i < 20 && !rv; i++) @(posedge clk);
    rry <= 1'b1;
    @(posedge clk);
    rry <= 1'b0;
    chk(rdat, exp);
    chk({30'h0, rresp}, {30'h0, er});
    if (i >= 20) results_late();
  endtask
  // A handshake that never came ends the run as a failure
  task results_late;
    error_cnt++;
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    results();
  endtask
  task t_ts;
    chk({15'h0, ts2}, 32'h00000183);
    rd(`VTR_TS_ADJ_OFS, 32'h000000d3, `VTR_RESP_OKAY);
    chk({15'h0, ts}, 32'h000000d3);
    wr(`VTR_TS_ADJ_OFS, 32'hffffffff, 4'hf, `VTR_RESP_OKAY);
    rd(`VTR_TS_ADJ_OFS, 32'h0001ffff, `VTR_RESP_OKAY);
    wr(`VTR_TS_ADJ_OFS, 32'h00000012, 4'h1, `VTR_RESP_OKAY);
    rd(`VTR_TS_ADJ_OFS, 32'h0001ff12, `VTR_RESP_OKAY);
    chk({15'h0, ts}, 32'h0001ff12);
    $display("Latency register test done");
  endtask
  // Reduced build: transmit keeps strip and tag, receive keeps translation only
  task t_tbl;
    wr(`VTR_TX_TBL_BASE + 18'h3ffc, 32'hffffffff, 4'hf, `VTR_RESP_OKAY);
    wr(`VTR_TX_TBL_BASE, 32'h00002abc, 4'hf, `VTR_RESP_OKAY);
    wr(`VTR_RX_TBL_BASE, 32'h00001234, 4'hf, `VTR_RESP_OKAY);
    rd(`VTR_TX_TBL_BASE + 18'h3ffc, 32'h00003fff, `VTR_RESP_OKAY);
    chk(rdat2, 32'h00003000);
    rd(`VTR_TX_TBL_BASE, 32'h00002abc, `VTR_RESP_OKAY);
    chk(rdat2, 32'h00002000);
    rd(`VTR_RX_TBL_BASE, 32'h00001234, `VTR_RESP_OKAY);
    chk(rdat2, 32'h00000234);
    tvid <= 12'hfff;
    rvid <= 12'h000;
    repeat (2) @(posedge clk);
    chk({18'h0, te}, 32'h00003fff);
    chk({18'h0, re}, 32'h00001234);
    chk({18'h0, te2}, 32'h00003000);
    chk({18'h0, re2}, 32'h00000234);
    $display("Table test done");
  endtask
  task t_map;
    rd(18'h0c000, 32'h0, `VTR_RESP_DECERR);
    wr(18'h00400, 32'h0, 4'hf, `VTR_RESP_DECERR);
    for (int k = 0; k < 4; k++) rd(fa[k], fe[k], `VTR_RESP_OKAY);
    wr(18'h11100, 32'hcafe0001, 4'h3, `VTR_RESP_OKAY);
    chk({14'h0, fwd_last.addr}, 32'h00011100);
    chk(fwd_last.wdata, 32'hcafe0001);
    chk({25'h0, fwd_last.region, fwd_last.wstrb}, 32'h00000053);
    $display("Address map test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_ts();
    t_tbl();
    t_map();
    results();
  end
endmodule
